// ==== rtl/limit_alarm.sv ====
// One limit alarm with hysteresis and on/off qualification delays.
`timescale 1ns/100ps
`default_nettype none
module limit_alarm #(
    parameter bit HIGH_TYPE = 1'b1
) (
    input  wire logic                                 core_clk,
    input  wire logic                                 reset_n,
    input  wire logic                                 tick,
    input  wire logic signed [pv_cond_pkg::PV_W-1:0]  value,
    input  wire logic signed [pv_cond_pkg::PV_W-1:0]  set_value,
    input  wire logic        [pv_cond_pkg::PV_W-1:0]  hysteresis,
    input  wire logic        [pv_cond_pkg::DLY_W-1:0] on_delay,
    input  wire logic        [pv_cond_pkg::DLY_W-1:0] off_delay,
    output logic                                      alarm
);
    import pv_cond_pkg::*;

    typedef struct packed {
        logic             on;
        logic [DLY_W-1:0] cnt;
    } alarm_state_t;

    alarm_state_t s_q;
    alarm_state_t s_d;

    logic signed [PV_W+1:0] v;
    logic signed [PV_W+1:0] sp;
    logic signed [PV_W+1:0] hy;
    logic                   trip;
    logic                   rel;

    always_comb begin
        s_d  = s_q;
        v    = {{2{value[PV_W-1]}}, value};
        sp   = {{2{set_value[PV_W-1]}}, set_value};
        hy   = {2'b00, hysteresis};
        // Only this alarm's own limit is looked at, so limits may sit in any order
        trip = HIGH_TYPE ? (v > sp) : (v < sp);
        // Release uses the limit in force now, so a raised limit applies at once
        rel  = HIGH_TYPE ? (v < sp - hy) : (v > sp + hy);
        if (tick) begin
            if (!s_q.on) begin
                if (trip) begin
                    if (s_q.cnt + 16'h0001 >= on_delay) begin
                        s_d.on  = 1'b1;
                        s_d.cnt = DLY_RST;
                    end else begin
                        s_d.cnt = s_q.cnt + 16'h0001;
                    end
                end else begin
                    s_d.cnt = DLY_RST;
                end
            end else begin
                if (rel) begin
                    if (s_q.cnt + 16'h0001 >= off_delay) begin
                        s_d.on  = 1'b0;
                        s_d.cnt = DLY_RST;
                    end else begin
                        s_d.cnt = s_q.cnt + 16'h0001;
                    end
                end else begin
                    s_d.cnt = DLY_RST;
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign alarm = s_q.on;

endmodule : limit_alarm
`default_nettype wire

// ==== rtl/pv_cond_pkg.sv ====
// Constants and field sizes shared by the process value conditioning block.
package pv_cond_pkg;

    localparam int CODE_W = 16;
    localparam int PV_W   = 16;
    localparam int DLY_W  = 16;
    localparam int DATE_W = 32;

    // Input code is percent of span in steps of 0.01 %
    localparam logic [31:0]       CODE_FULL       = 32'h0000_2710;
    localparam logic [CODE_W-1:0] INRUSH_ARM_CODE = 16'h00c8;
    localparam logic [CODE_W-1:0] SQRT_UP_CODE    = 16'h0032;
    localparam logic [CODE_W-1:0] SQRT_DN_CODE    = 16'h001e;

    localparam logic [DATE_W-1:0] DATE_BLANK = 32'hffff_ffff;
    localparam logic [PV_W-1:0]   PV_RST     = 16'h0000;
    localparam logic [CODE_W-1:0] CODE_RST   = 16'h0000;
    localparam logic [DLY_W-1:0]  DLY_RST    = 16'h0000;

    typedef enum logic [1:0] {
        CAL_BOOT,
        CAL_READ,
        CAL_IDLE,
        CAL_WRITE
    } cal_state_t;

endpackage : pv_cond_pkg

// ==== rtl/pv_conditioning.sv ====
// Process value conditioning: root, scaling, limit alarms, inrush arming, calibration date.
`timescale 1ns/100ps
`default_nettype none
module pv_conditioning (
    input  wire logic                                  core_clk,
    input  wire logic                                  reset_n,
    input  wire logic                                  sample_valid,
    input  wire logic        [pv_cond_pkg::CODE_W-1:0] sample_code,
    input  wire logic                                  input_open,
    input  wire logic                                  overrange_high,
    input  wire logic                                  sqrt_enable,
    input  wire logic signed [pv_cond_pkg::PV_W-1:0]   range_max,
    input  wire logic signed [pv_cond_pkg::PV_W-1:0]   range_min,
    input  wire logic signed [pv_cond_pkg::PV_W-1:0]   upper_upper_set,
    input  wire logic signed [pv_cond_pkg::PV_W-1:0]   upper_set,
    input  wire logic signed [pv_cond_pkg::PV_W-1:0]   lower_set,
    input  wire logic signed [pv_cond_pkg::PV_W-1:0]   lower_lower_set,
    input  wire logic        [pv_cond_pkg::PV_W-1:0]   alarm_hysteresis,
    input  wire logic        [pv_cond_pkg::DLY_W-1:0]  alarm_on_delay,
    input  wire logic        [pv_cond_pkg::DLY_W-1:0]  alarm_off_delay,
    input  wire logic                                  cal_update_req,
    input  wire logic        [pv_cond_pkg::DATE_W-1:0] cal_new_date,
    input  wire logic                                  nvm_rd_done,
    input  wire logic                                  nvm_rd_present,
    input  wire logic                                  nvm_rd_fault,
    input  wire logic        [pv_cond_pkg::DATE_W-1:0] nvm_rd_data,
    input  wire logic                                  nvm_wr_done,
    input  wire logic                                  nvm_wr_fail,
    output logic signed      [pv_cond_pkg::PV_W-1:0]   process_value,
    output logic                                       process_value_valid,
    output logic                                       sqrt_region,
    output logic                                       inrush_limit_engaged,
    output logic                                       upper_upper_limit_alarm,
    output logic                                       upper_limit_alarm,
    output logic                                       lower_limit_alarm,
    output logic                                       lower_lower_limit_alarm,
    output logic             [pv_cond_pkg::DATE_W-1:0] cal_date,
    output logic                                       cal_due_notice,
    output logic                                       cal_expired,
    output logic                                       cal_update_busy,
    output logic                                       nvm_error_flag,
    output logic                                       setting_error_indicator,
    output logic                                       nvm_rd_req,
    output logic                                       nvm_wr_req,
    output logic             [pv_cond_pkg::DATE_W-1:0] nvm_wr_data
);
    import pv_cond_pkg::*;

    // Every register of the block sits in this one record, except the state held inside the four limit alarms
    typedef struct packed {
        logic signed [PV_W-1:0] pv;
        logic                   pv_valid;
        logic                   sqrt_on;
        logic                   first_seen;
        logic                   inrush_armed;
        logic                   inrush_on;
        cal_state_t             cal;
        logic [DATE_W-1:0]      date;
        logic                   due;
        logic                   expired;
        logic                   busy;
        logic                   nvm_err;
        logic                   err_ind;
        logic                   rd_req;
        logic                   wr_req;
        logic [DATE_W-1:0]      wr_data;
    } core_state_t;

    core_state_t s_q;
    core_state_t s_d;

    // Bitwise integer root, unrolled by the tool into a fixed adder chain
    function automatic logic [15:0] isqrt(input logic [31:0] x);
        logic [31:0] rem;
        logic [31:0] root;
        logic [31:0] bitv;
        rem  = x;
        root = 32'h0000_0000;
        bitv = 32'h4000_0000;

        for (int i = 0; i < 16; i++) begin
            if (rem >= root + bitv) begin
                rem  = rem - (root + bitv);
                root = (root >> 1) + bitv;
            end else begin
                root = root >> 1;
            end
            bitv = bitv >> 2;
        end

        return root[15:0];
    endfunction : isqrt

    // Maps percent code onto the range; a maximum below the minimum simply gives a negative slope
    function automatic logic signed [PV_W-1:0] scale_pv(
        input logic [CODE_W-1:0]      code,
        input logic signed [PV_W-1:0] lo,
        input logic signed [PV_W-1:0] hi
    );
        logic signed [PV_W:0]   span;
        logic signed [33:0]     prod;
        logic signed [33:0]     quot;

        span = {hi[PV_W-1], hi} - {lo[PV_W-1], lo};
        prod = $signed({1'b0, code}) * span;
        quot = prod / $signed({2'b00, CODE_FULL});

        return PV_W'(quot + {{18{lo[PV_W-1]}}, lo});
    endfunction : scale_pv

    logic                   root_region;
    logic [CODE_W-1:0]      lin_code;
    logic signed [PV_W-1:0] scaled;

    always_comb begin
        s_d = s_q;
        s_d.pv_valid = 1'b0;

        // Region choice with hysteresis keeps the output from chattering near zero flow
        root_region = s_q.sqrt_on;
        if (!sqrt_enable) begin
            root_region = 1'b0;
        end else if (!s_q.sqrt_on && sample_code >= SQRT_UP_CODE) begin
            root_region = 1'b1;
        end else if (s_q.sqrt_on && sample_code <= SQRT_DN_CODE) begin
            root_region = 1'b0;
        end

        if (root_region) begin
            lin_code = isqrt(32'(sample_code) * CODE_FULL);
        end else begin
            lin_code = sample_code;
        end

        scaled = scale_pv(lin_code, range_min, range_max);

        if (sample_valid) begin
            s_d.sqrt_on  = root_region;
            s_d.pv_valid = 1'b1;
            if (input_open) begin
                s_d.pv = overrange_high ? range_max : range_min;
            end else begin
                s_d.pv = scaled;
            end

            // Arming is judged only on the very first sample after start-up
            if (!s_q.first_seen) begin
                s_d.first_seen   = 1'b1;
                s_d.inrush_armed = (lin_code < INRUSH_ARM_CODE);
            end else if (s_q.inrush_armed && lin_code > INRUSH_ARM_CODE) begin
                s_d.inrush_armed = 1'b0;
                s_d.inrush_on    = 1'b1;
            end
        end

        // One boot read per reset, then writes on request
        case (s_q.cal)
            CAL_BOOT: begin
                s_d.rd_req = 1'b1;
                s_d.cal    = CAL_READ;
            end

            CAL_READ: begin
                if (nvm_rd_done) begin
                    s_d.rd_req = 1'b0;
                    s_d.cal    = CAL_IDLE;

                    if (nvm_rd_fault) begin
                        s_d.nvm_err = 1'b1;
                        s_d.err_ind = 1'b1;
                        s_d.date    = DATE_BLANK;
                        s_d.due     = 1'b1;
                        s_d.expired = 1'b1;
                    end else if (!nvm_rd_present) begin
                        s_d.date    = DATE_BLANK;
                        s_d.due     = 1'b1;
                        s_d.expired = 1'b1;
                    end else begin
                        s_d.date    = nvm_rd_data;
                        s_d.due     = 1'b0;
                        s_d.expired = 1'b0;
                    end
                end
            end

            CAL_IDLE: begin
                if (cal_update_req) begin
                    s_d.busy    = 1'b1;
                    s_d.wr_req  = 1'b1;
                    s_d.wr_data = cal_new_date;
                    s_d.cal     = CAL_WRITE;
                end
            end

            CAL_WRITE: begin
                // Busy drops only when the memory reports the write finished
                if (nvm_wr_done) begin
                    s_d.busy   = 1'b0;
                    s_d.wr_req = 1'b0;
                    s_d.cal    = CAL_IDLE;

                    if (nvm_wr_fail) begin
                        // Indicator waits for restart, when the bad date is read back
                        s_d.nvm_err = 1'b1;
                    end else begin
                        s_d.date    = s_q.wr_data;
                        s_d.due     = 1'b0;
                        s_d.expired = 1'b0;
                    end
                end
            end

            default: begin
                s_d.cal = CAL_BOOT;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q              <= '0;
            s_q.pv           <= PV_RST;
            s_q.cal          <= CAL_BOOT;
            // Date reads blank until the boot read answers
            s_q.date         <= DATE_BLANK;
        end else begin
            s_q <= s_d;
        end
    end

    // Four copies; only the compare direction and the set value differ
    limit_alarm #(
        .HIGH_TYPE (1'b1)
    ) u_upper_upper (
        .core_clk   (core_clk),
        .reset_n    (reset_n),
        .tick       (s_q.pv_valid),
        .value      (s_q.pv),
        .set_value  (upper_upper_set),
        .hysteresis (alarm_hysteresis),
        .on_delay   (alarm_on_delay),
        .off_delay  (alarm_off_delay),
        .alarm      (upper_upper_limit_alarm)
    );

    limit_alarm #(
        .HIGH_TYPE (1'b1)
    ) u_upper (
        .core_clk   (core_clk),
        .reset_n    (reset_n),
        .tick       (s_q.pv_valid),
        .value      (s_q.pv),
        .set_value  (upper_set),
        .hysteresis (alarm_hysteresis),
        .on_delay   (alarm_on_delay),
        .off_delay  (alarm_off_delay),
        .alarm      (upper_limit_alarm)
    );

    limit_alarm #(
        .HIGH_TYPE (1'b0)
    ) u_lower (
        .core_clk   (core_clk),
        .reset_n    (reset_n),
        .tick       (s_q.pv_valid),
        .value      (s_q.pv),
        .set_value  (lower_set),
        .hysteresis (alarm_hysteresis),
        .on_delay   (alarm_on_delay),
        .off_delay  (alarm_off_delay),
        .alarm      (lower_limit_alarm)
    );

    limit_alarm #(
        .HIGH_TYPE (1'b0)
    ) u_lower_lower (
        .core_clk   (core_clk),
        .reset_n    (reset_n),
        .tick       (s_q.pv_valid),
        .value      (s_q.pv),
        .set_value  (lower_lower_set),
        .hysteresis (alarm_hysteresis),
        .on_delay   (alarm_on_delay),
        .off_delay  (alarm_off_delay),
        .alarm      (lower_lower_limit_alarm)
    );

    // Outputs are register fields, no logic behind the flops
    assign process_value           = s_q.pv;
    assign process_value_valid     = s_q.pv_valid;
    assign sqrt_region             = s_q.sqrt_on;
    assign inrush_limit_engaged    = s_q.inrush_on;
    assign cal_date                = s_q.date;
    assign cal_due_notice          = s_q.due;
    assign cal_expired             = s_q.expired;
    assign cal_update_busy         = s_q.busy;
    assign nvm_error_flag          = s_q.nvm_err;
    assign setting_error_indicator = s_q.err_ind;
    assign nvm_rd_req              = s_q.rd_req;
    assign nvm_wr_req              = s_q.wr_req;
    assign nvm_wr_data             = s_q.wr_data;

endmodule : pv_conditioning
`default_nettype wire

// ==== verif/nvm_model.sv ====
// Behavioural nonvolatile date store answering reads and writes after a set latency.
`timescale 1ns/100ps
`default_nettype none
module nvm_model (
    input wire logic        core_clk,
    input wire logic        reset_n,
    input wire logic        rd_req,
    input wire logic        wr_req,
    input wire logic        present,
    input wire logic        fault,
    input wire logic        wr_bad,
    input wire logic [31:0] date,
    input wire logic [3:0]  lat,
    output logic            rd_done,
    output logic            rd_present,
    output logic            rd_fault,
    output logic [31:0]     rd_data,
    output logic            wr_done,
    output logic            wr_fail
);
    logic [3:0] cnt_q;
    // Idle lines carry the inverse, so a stale sample shows up
    assign rd_present = rd_done ? present : !present;
    assign rd_fault   = rd_done ? fault : !fault;
    assign rd_data    = rd_done ? date : ~date;
    assign wr_fail    = wr_done ? wr_bad : !wr_bad;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q   <= 4'h0;
            rd_done <= 1'b0;
            wr_done <= 1'b0;
        end else begin
            rd_done <= 1'b0;
            wr_done <= 1'b0;
            if ((rd_req && !rd_done) || (wr_req && !wr_done)) begin
                cnt_q <= (cnt_q == lat) ? 4'h0 : cnt_q + 4'h1;
                if (cnt_q == lat) begin
                    rd_done <= rd_req;
                    wr_done <= wr_req && !rd_req;
                end
            end
        end
    end
endmodule : nvm_model
`default_nettype wire

// ==== verif/pv_cond_checker.sv ====
// Port-level assertions for the process value conditioning block.
`timescale 1ns/100ps
`default_nettype none
module pv_cond_checker (
    input wire logic                                  core_clk,
    input wire logic                                  reset_n,
    input wire logic                                  sample_valid,
    input wire logic        [pv_cond_pkg::CODE_W-1:0] sample_code,
    input wire logic                                  input_open,
    input wire logic                                  overrange_high,
    input wire logic                                  sqrt_enable,
    input wire logic signed [pv_cond_pkg::PV_W-1:0]   range_max,
    input wire logic signed [pv_cond_pkg::PV_W-1:0]   range_min,
    input wire logic signed [pv_cond_pkg::PV_W-1:0]   upper_upper_set,
    input wire logic signed [pv_cond_pkg::PV_W-1:0]   lower_lower_set,
    input wire logic                                  nvm_rd_done,
    input wire logic                                  nvm_rd_present,
    input wire logic                                  nvm_rd_fault,
    input wire logic                                  nvm_wr_done,
    input wire logic                                  nvm_wr_fail,
    input wire logic signed [pv_cond_pkg::PV_W-1:0]   process_value,
    input wire logic                                  process_value_valid,
    input wire logic                                  sqrt_region,
    input wire logic                                  inrush_limit_engaged,
    input wire logic                                  upper_upper_limit_alarm,
    input wire logic                                  lower_lower_limit_alarm,
    input wire logic        [pv_cond_pkg::DATE_W-1:0] cal_date,
    input wire logic                                  cal_due_notice,
    input wire logic                                  cal_expired,
    input wire logic                                  cal_update_busy,
    input wire logic                                  nvm_error_flag,
    input wire logic                                  setting_error_indicator,
    input wire logic                                  nvm_rd_req,
    input wire logic                                  nvm_wr_req
);
    import pv_cond_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    sequence s_rd_fault; nvm_rd_req && nvm_rd_done && nvm_rd_fault; endsequence
    sequence s_rd_blank; nvm_rd_req && nvm_rd_done && !nvm_rd_present && !nvm_rd_fault; endsequence
    sequence s_blank; cal_date == DATE_BLANK && cal_due_notice && cal_expired; endsequence
    sequence s_open(logic hi); sample_valid && input_open && overrange_high == hi; endsequence
    property p_valid; sample_valid |=> process_value_valid; endproperty
    property p_open_hi; s_open(1'b1) |=> process_value == range_max; endproperty
    property p_open_lo; s_open(1'b0) |=> process_value == range_min; endproperty
    property p_sqrt_up;
        sample_valid && sqrt_enable && !input_open && sample_code >= SQRT_UP_CODE |=> sqrt_region;
    endproperty
    property p_sqrt_dn;
        sample_valid && sqrt_enable && sample_code <= SQRT_DN_CODE |=> !sqrt_region;
    endproperty
    property p_inrush; inrush_limit_engaged |=> inrush_limit_engaged; endproperty
    property p_busy; cal_update_busy |-> nvm_wr_req; endproperty
    property p_wr_fail; nvm_wr_req && nvm_wr_done && nvm_wr_fail |=> nvm_error_flag; endproperty
    property p_rd_fault; s_rd_fault |=> s_blank ##0 (nvm_error_flag && setting_error_indicator);
    endproperty
    property p_rd_blank; s_rd_blank |=> s_blank; endproperty
    property p_uu; $rose(upper_upper_limit_alarm) |-> $past(process_value) > upper_upper_set;
    endproperty
    property p_ll; $rose(lower_lower_limit_alarm) |-> $past(process_value) < lower_lower_set;
    endproperty
    a_valid: assert property (p_valid) else $error("valid pulse missing");
    a_open_hi: assert property (p_open_hi) else $error("open input not at max");
    a_open_lo: assert property (p_open_lo) else $error("open input not at min");
    a_sqrt_up: assert property (p_sqrt_up) else $error("root region not entered");
    a_sqrt_dn: assert property (p_sqrt_dn) else $error("root region not left");
    a_inrush: assert property (p_inrush) else $error("inrush dropped");
    a_busy: assert property (p_busy) else $error("busy without write");
    a_wr_fail: assert property (p_wr_fail) else $error("write fail not flagged");
    a_rd_fault: assert property (p_rd_fault) else $error("faulty date not flagged");
    a_rd_blank: assert property (p_rd_blank) else $error("blank date not flagged");
    a_uu: assert property (p_uu) else $error("upper alarm without cause");
    a_ll: assert property (p_ll) else $error("lower alarm without cause");
endmodule : pv_cond_checker
`default_nettype wire

// ==== verif/test_pv_conditioning.sv ====
// Self-checking bench for the process value conditioning block.
`timescale 1ns/100ps
`default_nettype none
module test_pv_conditioning;
    import pv_cond_pkg::*;
    logic core_clk = 1'b0, reset_n = 1'b0, sample_valid = 1'b0, input_open = 1'b0;
    logic overrange_high = 1'b0, sqrt_enable = 1'b0, cal_update_req = 1'b0;
    logic [15:0] sample_code = 16'h0000, range_max = 16'h0000, range_min = 16'h0fa0;
    logic [15:0] uu_set = 16'h0dac, u_set = 16'h0bb8, l_set = 16'h03e8, ll_set = 16'h0e74;
    logic [15:0] hyst = 16'h0064, on_dly = 16'h0003, off_dly = 16'h0003, pv;
    logic [31:0] cal_new_date = 32'h0a0b_0c0d, nvm_wr_data, cal_date, rd_data, m_date;
    logic rd_done, rd_present, rd_fault, wr_done, wr_fail, pv_valid, sq, inrush;
    logic uu, u, l, ll, due, expd, busy, err, ind, rd_req, wr_req;
    logic m_present = 1'b1, m_fault = 1'b0, m_wbad = 1'b0;
    logic [3:0] m_lat = 4'h0;
    int n_mismatch = 0, samples_checked = 0;
    always #2 core_clk = ~core_clk;
    pv_conditioning dut (.core_clk(core_clk), .reset_n(reset_n), .sample_valid(sample_valid),
        .sample_code(sample_code), .input_open(input_open), .overrange_high(overrange_high),
        .sqrt_enable(sqrt_enable), .range_max(range_max), .range_min(range_min),
        .upper_upper_set(uu_set), .upper_set(u_set), .lower_set(l_set), .lower_lower_set(ll_set),
        .alarm_hysteresis(hyst), .alarm_on_delay(on_dly), .alarm_off_delay(off_dly),
        .cal_update_req(cal_update_req), .cal_new_date(cal_new_date), .nvm_rd_done(rd_done),
        .nvm_rd_present(rd_present), .nvm_rd_fault(rd_fault), .nvm_rd_data(rd_data),
        .nvm_wr_done(wr_done), .nvm_wr_fail(wr_fail), .process_value(pv),
        .process_value_valid(pv_valid), .sqrt_region(sq), .inrush_limit_engaged(inrush),
        .upper_upper_limit_alarm(uu), .upper_limit_alarm(u), .lower_limit_alarm(l),
        .lower_lower_limit_alarm(ll), .cal_date(cal_date), .cal_due_notice(due),
        .cal_expired(expd), .cal_update_busy(busy), .nvm_error_flag(err),
        .setting_error_indicator(ind), .nvm_rd_req(rd_req), .nvm_wr_req(wr_req),
        .nvm_wr_data(nvm_wr_data));
    nvm_model nvm (.core_clk(core_clk), .reset_n(reset_n), .rd_req(rd_req), .wr_req(wr_req),
        .present(m_present), .fault(m_fault), .wr_bad(m_wbad), .date(m_date), .lat(m_lat),
        .rd_done(rd_done), .rd_present(rd_present), .rd_fault(rd_fault), .rd_data(rd_data),
        .wr_done(wr_done), .wr_fail(wr_fail));
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic finish_test;
        $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : finish_test
    task automatic do_reset(input logic p, input logic f);
        int i;
        m_present = p;
        m_fault = f;
        reset_n = 1'b0;
        repeat (10) @(negedge core_clk);
        reset_n = 1'b1;
        repeat (2) @(negedge core_clk);
        for (i = 0; i < 50 && rd_req !== 1'b0; i++) @(negedge core_clk);
        @(negedge core_clk);
    endtask : do_reset
    task automatic samp(input logic [15:0] c);
        sample_code = c;
        sample_valid = 1'b1;
        @(negedge core_clk);
        sample_valid = 1'b0;
        repeat (2) @(negedge core_clk);
    endtask : samp
    task automatic t_boot;
        do_reset(1'b0, 1'b0);
        chk({cal_date, due, expd, err, ind}, {DATE_BLANK, 4'b1100});
        do_reset(1'b1, 1'b1);
        chk({cal_date, due, expd, err, ind}, {DATE_BLANK, 4'b1111});
        do_reset(1'b1, 1'b0);
        chk({cal_date, due, expd, err, ind}, {m_date, 4'b0000});
    endtask : t_boot
    task automatic t_update(input logic bad);
        int i;
        m_wbad = bad;
        m_lat = 4'h5;
        cal_update_req = 1'b1;
        @(negedge core_clk);
        cal_update_req = 1'b0;
        chk({busy, wr_req, nvm_wr_data}, {2'b11, cal_new_date});
        for (i = 0; i < 50 && busy !== 1'b0; i++) @(negedge core_clk);
        if (bad) chk({cal_date, err, ind}, {~cal_new_date, 2'b10});
        else chk({cal_date, due, expd, err}, {cal_new_date, 3'b000});
        m_lat = 4'h0;
        cal_new_date = ~cal_new_date; // Next call writes a new date
    endtask : t_update
    // Reversed range: 0 % gives 4000, 100 % gives 0
    task automatic t_scale;
        logic [15:0] codes [3] = '{16'h0000, 16'h09c4, 16'h2710};
        logic [15:0] vals [3] = '{16'h0fa0, 16'h0bb8, 16'h0000};
        foreach (codes[k]) begin
            samp(codes[k]);
            chk(pv, vals[k]);
        end
    endtask : t_scale
    task automatic t_delay;
        logic [12:0] trip = 13'b0110111001000;
        logic [12:0] exp = 13'b0000001111110;
        for (int k = 12; k >= 0; k--) begin
            samp(trip[k] ? 16'h03e8 : 16'h1388);
            chk(u, exp[k]);
        end
    endtask : t_delay
    // Lower-lower limit sits above the other three limits on purpose, until the upper limit is raised past it
    task automatic t_limits;
        on_dly = 16'h0001;
        off_dly = 16'h0001;
        samp(16'h2328);
        chk({uu, u, l, ll}, 4'b0011);
        samp(16'h03e8);
        chk({uu, u, l, ll}, 4'b1101);
        u_set = 16'h0e42;
        samp(16'h03e8);
        chk(u, 1'b1);
        u_set = 16'h0ea6;
        samp(16'h03e8);
        chk(u, 1'b0);
    endtask : t_limits
    task automatic t_open;
        input_open = 1'b1;
        overrange_high = 1'b1;
        samp(16'h1388);
        chk(pv, range_max);
        overrange_high = 1'b0;
        samp(16'h1388);
        chk(pv, range_min);
        input_open = 1'b0;
    endtask : t_open
    task automatic t_sqrt;
        logic [15:0] codes [4] = '{16'h0028, 16'h0032, 16'h0028, 16'h001e};
        logic [16:0] vals [4] = '{17'h00028, 17'h102c3, 17'h10278, 17'h0001e};
        range_min = 16'h0000;
        range_max = 16'h2710;
        sqrt_enable = 1'b1;
        foreach (codes[k]) begin
            samp(codes[k]);
            chk({sq, pv}, vals[k]);
        end
        sqrt_enable = 1'b0;
    endtask : t_sqrt
    task automatic t_inrush;
        do_reset(1'b1, 1'b0);
        samp(16'h0064);
        chk(inrush, 1'b0);
        samp(16'h012c);
        chk(inrush, 1'b1);
        do_reset(1'b1, 1'b0);
        samp(16'h012c);
        samp(16'h0190);
        chk(inrush, 1'b0);
    endtask : t_inrush
    initial begin
        m_date = 32'h1234_5678;
        t_boot();
        t_update(1'b0);
        t_update(1'b1);
        do_reset(1'b1, 1'b1);
        chk(ind, 1'b1);
        t_scale();
        t_delay();
        t_limits();
        t_open();
        t_sqrt();
        t_inrush();
        finish_test();
    end
    initial begin
        #200000;
        n_mismatch++;
        finish_test();
    end
endmodule : test_pv_conditioning
bind pv_conditioning pv_cond_checker chk_i (.*);
`default_nettype wire
